//--- hw/pcstx_pkg.sv
// constants and types shared by the transmit scramble and encode block
package pcstx_pkg;

  // ==========================================================
  // register map
  localparam logic [11:0] PCSTX_CTRL_OFFSET = 12'h000;
  localparam logic [11:0] PCSTX_STATUS_OFFSET = 12'h004;
  localparam logic [11:0] PCSTX_SCR_LO_OFFSET = 12'h008;
  localparam logic [11:0] PCSTX_SCR_HI_OFFSET = 12'h00C;

  // ==========================================================
  // control field positions
  localparam int PCSTX_CTRL_MASTER_BIT = 0;
  localparam int PCSTX_CTRL_MODE_LSB = 1;
  localparam int PCSTX_CTRL_RCVR_OK_BIT = 3;
  localparam int PCSTX_CTRL_RESET_BIT = 4;
  localparam logic [4:0] PCSTX_CTRL_RESET_VALUE = 5'h11;

  // ==========================================================
  // status field positions
  localparam int PCSTX_STAT_TRELLIS_LSB = 9;
  localparam int PCSTX_STAT_ODD_BIT = 12;
  localparam int PCSTX_STAT_WINDOW_BIT = 13;

  // ==========================================================
  // scrambler
  localparam int PCSTX_SCR_WIDTH = 33;
  localparam int PCSTX_TAP_MASTER = 13;
  localparam int PCSTX_TAP_SLAVE = 20;
  localparam logic [32:0] PCSTX_SCR_SEED = 33'h0_0000_0001;
  localparam logic [7:0] PCSTX_CEXT_CODE = 8'h0F;

  typedef enum logic [1:0] {
    pcstx_send_n,
    pcstx_send_i,
    pcstx_send_z
  } pcstx_mode_type;

endpackage

//--- hw/pcstx_scr_if.sv
// scrambler state and derived pseudorandom words passed between modules
`timescale 1ns/10ps
interface pcstx_scr_if;
  logic [32:0] state;
  logic [3:0] word_a;
  logic [3:0] word_b;
  logic [3:0] word_c;
  modport source (output state, output word_a, output word_b, output word_c);
  modport sink (input state, input word_a, input word_b, input word_c);
endinterface

//--- hw/pcstx_scrambler.sv
// side-stream scrambler with derived word generation
`timescale 1ns/10ps
module pcstx_scrambler
  import pcstx_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic pcs_reset,
  input wire logic master,
  pcstx_scr_if.source scr
);
  logic [32:0] state;
  logic [32:0] next_state;
  logic fb;

  // ==========================================================
  // shift register
  always_comb begin
    if (master) begin
      fb = state[PCSTX_TAP_MASTER-1] ^ state[PCSTX_SCR_WIDTH-1];
    end else begin
      fb = state[PCSTX_TAP_SLAVE-1] ^ state[PCSTX_SCR_WIDTH-1];
    end
    if (pcs_reset) begin
      next_state = PCSTX_SCR_SEED;
    end else begin
      next_state = {state[31:0], fb};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= PCSTX_SCR_SEED;
    end else if (ce) begin
      state <= next_state;
    end
  end

  // ==========================================================
  // derived words, same taps for both configurations
  always_comb begin
    scr.state = state;
    scr.word_b[0] = state[0];
    scr.word_b[1] = state[3] ^ state[8];
    scr.word_b[2] = state[6] ^ state[16];
    scr.word_b[3] = state[9] ^ state[14] ^ state[19] ^ state[24];
    scr.word_a[0] = state[4] ^ state[6];
    scr.word_a[1] = state[7] ^ state[9] ^ state[12] ^ state[14];
    scr.word_a[2] = state[10] ^ state[12] ^ state[20] ^ state[22];
    scr.word_a[3] = state[13] ^ state[15] ^ state[18] ^ state[20]
                  ^ state[23] ^ state[25] ^ state[28] ^ state[30];
    scr.word_c[0] = state[1] ^ state[5];
    scr.word_c[1] = state[4] ^ state[8] ^ state[9] ^ state[13];
    scr.word_c[2] = state[7] ^ state[11] ^ state[17] ^ state[21];
    scr.word_c[3] = state[10] ^ state[14] ^ state[15] ^ state[19]
                  ^ state[20] ^ state[24] ^ state[25] ^ state[29];
  end
endmodule

//--- hw/pcstx_history.sv
// data window history, symbol parity and previous word b
`timescale 1ns/10ps
module pcstx_history
  import pcstx_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic pcs_reset,
  input wire logic tx_enable,
  input wire logic [3:1] word_b,
  output logic enable_d1,
  output logic enable_d2,
  output logic odd,
  output logic [3:1] prev_b
);
  logic next_enable_d1;
  logic next_enable_d2;
  logic next_odd;
  logic [3:1] next_prev_b;

  always_comb begin
    if (pcs_reset) begin
      next_enable_d1 = 1'b0;
      next_enable_d2 = 1'b0;
      next_odd = 1'b0;
      next_prev_b = 3'h0;
    end else begin
      next_enable_d1 = tx_enable;
      next_enable_d2 = enable_d1;
      next_odd = ~odd;
      next_prev_b = word_b;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enable_d1 <= 1'b0;
      enable_d2 <= 1'b0;
      odd <= 1'b0;
      prev_b <= 3'h0;
    end else if (ce) begin
      enable_d1 <= next_enable_d1;
      enable_d2 <= next_enable_d2;
      odd <= next_odd;
      prev_b <= next_prev_b;
    end
  end
endmodule

//--- hw/pcstx_encode.sv
// transmit whitening and convolutional encoding with apb control
//
// The APB slave port and the address map were decided locally.
`timescale 1ns/10ps

module pcstx_encode (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic tx_enable,
  input wire logic tx_error,
  input wire logic [7:0] txd,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [8:0] encoder_output_word,
  output logic [3:0] derived_word_c,
  output logic csreset
);
  import pcstx_pkg::*;

  // ==========================================================
  // declarations
  pcstx_scr_if scr_bus ();
  logic [4:0] ctrl;
  logic [4:0] next_ctrl;
  logic [31:0] next_prdata;
  logic next_pready;
  logic next_pslverr;
  logic access;
  logic pcs_reset;
  logic master;
  logic rcvr_ok;
  pcstx_mode_type tx_mode;
  logic enable_d1;
  logic enable_d2;
  logic odd;
  logic [3:1] prev_b;
  logic [7:0] whitening_word;
  logic flush;
  logic cext;
  logic cext_err;
  logic [8:0] enc_word;
  logic [2:0] trellis;
  logic [2:0] next_trellis;
  logic [8:0] next_out;
  logic [3:0] next_word_c;
  logic next_csreset;

  assign master = ctrl[PCSTX_CTRL_MASTER_BIT];
  assign rcvr_ok = ctrl[PCSTX_CTRL_RCVR_OK_BIT];
  assign pcs_reset = ctrl[PCSTX_CTRL_RESET_BIT];
  assign tx_mode = pcstx_mode_type'(ctrl[PCSTX_CTRL_MODE_LSB +: 2]);

  // ==========================================================
  // submodules
  pcstx_scrambler u_scrambler (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .pcs_reset(pcs_reset),
    .master(master),
    .scr(scr_bus.source)
  );

  pcstx_history u_history (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .pcs_reset(pcs_reset),
    .tx_enable(tx_enable),
    .word_b(scr_bus.word_b[3:1]),
    .enable_d1(enable_d1),
    .enable_d2(enable_d2),
    .odd(odd),
    .prev_b(prev_b)
  );

  // ==========================================================
  // apb slave, one wait state
  // pready is registered so every output stays a flop; costs one cycle
  assign access = psel & penable & ~pready;

  always_comb begin
    next_ctrl = ctrl;
    next_prdata = 32'h0000_0000;
    next_pready = access;
    next_pslverr = 1'b0;
    if (access) begin
      case (paddr)
        PCSTX_CTRL_OFFSET: begin
          if (pwrite) begin
            next_ctrl = pwdata[4:0];
          end
          next_prdata = {27'h000_0000, ctrl};
        end
        PCSTX_STATUS_OFFSET: begin
          next_prdata = {18'h0_0000, enable_d2, odd, trellis, encoder_output_word};
        end
        PCSTX_SCR_LO_OFFSET: begin
          next_prdata = scr_bus.state[31:0];
        end
        PCSTX_SCR_HI_OFFSET: begin
          next_prdata = {31'h0000_0000, scr_bus.state[32]};
        end
        default: begin
          next_pslverr = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= PCSTX_CTRL_RESET_VALUE;
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else if (ce) begin
      ctrl <= next_ctrl;
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
    end
  end

  // ==========================================================
  // whitening word
  always_comb begin
    if (enable_d2) begin
      whitening_word[7:4] = scr_bus.word_a;
    end else begin
      whitening_word[7:4] = 4'h0;
    end
    if (tx_mode == pcstx_send_z) begin
      whitening_word[3:1] = 3'h0;
      whitening_word[0] = 1'b0;
    end else begin
      whitening_word[0] = scr_bus.word_b[0];
      if (!odd) begin
        whitening_word[3:1] = scr_bus.word_b[3:1];
      end else begin
        whitening_word[3:1] = ~prev_b;
      end
    end
  end

  // ==========================================================
  // encoder output word
  always_comb begin
    flush = enable_d2 & ~tx_enable;
    cext = 1'b0;
    cext_err = 1'b0;
    if (!tx_enable) begin
      if (txd == PCSTX_CEXT_CODE) begin
        cext = tx_error;
      end else begin
        cext_err = tx_error;
      end
    end
    if (enable_d2 && !flush) begin
      enc_word[7:6] = whitening_word[7:6] ^ txd[7:6];
    end else if (flush) begin
      enc_word[7:6] = trellis[1:0];
    end else begin
      enc_word[7:6] = whitening_word[7:6];
    end
    if (enable_d2) begin
      enc_word[5:3] = whitening_word[5:3] ^ txd[5:3];
      enc_word[2] = whitening_word[2] ^ txd[2];
      enc_word[1] = whitening_word[1] ^ txd[1];
      enc_word[0] = whitening_word[0] ^ txd[0];
    end else begin
      enc_word[5:3] = whitening_word[5:3];
      enc_word[2] = whitening_word[2] ^ rcvr_ok;
      enc_word[1] = whitening_word[1] ^ cext_err;
      enc_word[0] = whitening_word[0] ^ cext;
    end
    // trellis bit 0 of this symbol is the previous bit 2
    next_trellis[0] = trellis[2];
    enc_word[8] = next_trellis[0];
    if (enable_d2) begin
      next_trellis[1] = enc_word[6] ^ trellis[0];
      next_trellis[2] = enc_word[7] ^ trellis[1];
    end else begin
      next_trellis[2:1] = 2'h0;
    end
  end

  // ==========================================================
  // output stage and trellis register
  always_comb begin
    if (pcs_reset) begin
      next_out = 9'h000;
      next_word_c = 4'h0;
      next_csreset = 1'b0;
    end else begin
      next_out = enc_word;
      next_word_c = scr_bus.word_c;
      next_csreset = flush;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trellis <= 3'h0;
      encoder_output_word <= 9'h000;
      derived_word_c <= 4'h0;
      csreset <= 1'b0;
    end else if (ce) begin
      if (pcs_reset) begin
        trellis <= 3'h0;
      end else begin
        trellis <= next_trellis;
      end
      encoder_output_word <= next_out;
      derived_word_c <= next_word_c;
      csreset <= next_csreset;
    end
  end
endmodule

//--- verif/pcstx_encode_chk.sv
// concurrent checks on the encoder top ports
`timescale 1ns/10ps
module pcstx_encode_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic tx_enable,
  input wire logic psel,
  input wire logic penable,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [8:0] encoder_output_word,
  input wire logic [3:0] derived_word_c,
  input wire logic csreset
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ==========================================================
  // bus answer
  property p_pulse; pready |=> !pready; endproperty
  a_pulse: assert property (p_pulse) else $error("ready held over one cycle");
  property p_answer; psel && penable && ce && !pready |=> pready; endproperty
  a_answer: assert property (p_answer) else $error("no answer one cycle after take");
  property p_cause; pready |-> $past(psel && penable); endproperty
  a_cause: assert property (p_cause) else $error("answer without access phase");
  property p_err; pslverr |-> pready && prdata == 32'h0000_0000; endproperty
  a_err: assert property (p_err) else $error("error answer malformed");
  // ==========================================================
  // symbol stream
  property p_hold;
    !ce |=> $stable(encoder_output_word) && $stable(derived_word_c) && $stable(csreset);
  endproperty
  a_hold: assert property (p_hold) else $error("outputs moved without strobe");
  property p_flush_now; csreset && $past(ce) |-> !$past(tx_enable); endproperty
  a_flush_now: assert property (p_flush_now) else $error("flush inside window");
  property p_flush_old;
    csreset && $past(ce) && $past(ce, 2) && $past(ce, 3) |-> $past(tx_enable, 3);
  endproperty
  a_flush_old: assert property (p_flush_old) else $error("flush without window");
  // trellis empties once the delayed window has been clear
  property p_trellis;
    $past(ce) && $past(ce, 2) && $past(ce, 3) && $past(ce, 4) && !$past(tx_enable, 4)
      |-> !encoder_output_word[8];
  endproperty
  a_trellis: assert property (p_trellis) else $error("trellis bit set idle");
endmodule

bind pcstx_encode pcstx_encode_chk i_pcstx_encode_chk (.pclk(pclk), .presetn(presetn),
  .ce(ce), .tx_enable(tx_enable), .psel(psel), .penable(penable), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .encoder_output_word(encoder_output_word),
  .derived_word_c(derived_word_c), .csreset(csreset));

//--- verif/pcstx_gmii_src.sv
// gmii transmit source with random frames and extension requests
`timescale 1ns/10ps
module pcstx_gmii_src (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [31:0] rnd,
  output logic tx_enable,
  output logic tx_error,
  output logic [7:0] txd
);
  logic [4:0] left;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_enable <= 1'h0;
      tx_error <= 1'h0;
      txd <= 8'h00;
      left <= 5'h00;
    end else begin
      tx_error <= rnd[8];
      // extension code half the time so both flag branches occur
      txd <= rnd[9] ? 8'h0F : rnd[7:0];
      tx_enable <= left != 5'h00;
      if (left != 5'h00) begin
        left <= left - 5'h01;
      end else if (rnd[15:13] == 3'h0) begin
        left <= rnd[20:16];
      end
    end
  end
endmodule

//--- verif/pcs_tx_scramble_encode_bench.sv
// self-checking bench for the transmit scramble and encode block
`timescale 1ns/10ps
module pcs_tx_scramble_encode_bench;
  import pcstx_pkg::*;
  logic pclk, presetn, ce, tx_enable, tx_error, psel, penable, pwrite, pready, pslverr;
  logic csreset, busy, odd, d1, d2, cr, xe, xf, er;
  logic [7:0] txd, ww;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rnd, rd;
  logic [8:0] encoder_output_word, ew;
  logic [3:0] derived_word_c, a, b, c;
  logic [32:0] s;
  logic [4:0] m_ctrl;
  logic [3:1] pb;
  logic [2:0] cs;
  int mismatches, n_checks;

  pcstx_encode i_pcstx_encode (.pclk(pclk), .presetn(presetn), .ce(ce),
    .tx_enable(tx_enable), .tx_error(tx_error), .txd(txd), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .encoder_output_word(encoder_output_word),
    .derived_word_c(derived_word_c), .csreset(csreset));
  pcstx_gmii_src i_pcstx_gmii_src (.pclk(pclk), .presetn(presetn), .rnd(rnd),
    .tx_enable(tx_enable), .tx_error(tx_error), .txd(txd));

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic stop_test;
    if (mismatches == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] wd);
    int n;
    @(posedge pclk);
    busy <= 1'h1;
    psel <= 1'h1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'h1;
    @(posedge pclk);
    // control takes effect at the take edge
    if (w && ad == PCSTX_CTRL_OFFSET) m_ctrl <= wd[4:0];
    n = 0;
    while (pready !== 1'h1 && n < 20) begin
      @(posedge pclk);
      n++;
    end
    if (n == 20) mismatches++;
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    busy <= 1'h0;
  endtask

  initial begin
    pclk = 1'h0;
    forever #5 pclk = ~pclk;
  end

  // strobe stays high during bus cycles, random otherwise
  always @(posedge pclk) begin
    rnd <= lfsr(rnd);
    ce <= busy || rnd[30:29] != 2'h0;
  end

  // ==========================================================
  // reference model
  always @(posedge pclk) begin
    if (!presetn) begin
      m_ctrl = PCSTX_CTRL_RESET_VALUE;
    end
    if (!presetn || (ce && m_ctrl[4])) begin
      s = PCSTX_SCR_SEED;
      {odd, d1, d2, cs, ew, c, cr, pb} = '0;
    end else if (ce) begin
      b = {s[9] ^ s[14] ^ s[19] ^ s[24], s[6] ^ s[16], s[3] ^ s[8], s[0]};
      a = {s[13] ^ s[15] ^ s[18] ^ s[20] ^ s[23] ^ s[25] ^ s[28] ^ s[30],
        s[10] ^ s[12] ^ s[20] ^ s[22], s[7] ^ s[9] ^ s[12] ^ s[14], s[4] ^ s[6]};
      c = {s[10] ^ s[14] ^ s[15] ^ s[19] ^ s[20] ^ s[24] ^ s[25] ^ s[29],
        s[7] ^ s[11] ^ s[17] ^ s[21], s[4] ^ s[8] ^ s[9] ^ s[13], s[1] ^ s[5]};
      ww[7:4] = d2 ? a : 4'h0;
      ww[3:0] = m_ctrl[2:1] == 2'h2 ? 4'h0 : {odd ? ~pb : b[3:1], b[0]};
      cr = d2 && !tx_enable;
      xe = !tx_enable && txd == PCSTX_CEXT_CODE && tx_error;
      xf = !tx_enable && txd != PCSTX_CEXT_CODE && tx_error;
      ew[7:6] = cr ? cs[1:0] : ww[7:6] ^ (d2 ? txd[7:6] : 2'h0);
      ew[5:0] = ww[5:0] ^ (d2 ? txd[5:0] : {3'h0, m_ctrl[3], xf, xe});
      cs = {d2 && (ew[7] ^ cs[1]), d2 && (ew[6] ^ cs[0]), cs[2]};
      ew[8] = cs[0];
      pb = b[3:1];
      odd = !odd;
      d2 = d1;
      d1 = tx_enable;
      s = {s[31:0], s[32] ^ (m_ctrl[0] ? s[12] : s[19])};
    end
    #1;
    if (presetn) check(32'({encoder_output_word, derived_word_c, csreset}), 32'({ew, c, cr}));
  end

  initial begin
    {presetn, ce, psel, penable, pwrite, busy} = '0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    rnd = 32'h2420_6f75;
    repeat (8) @(posedge pclk);
    presetn <= 1'h1;
    apb(1'h0, PCSTX_CTRL_OFFSET, 32'h0000_0000);
    check(rd, 32'(PCSTX_CTRL_RESET_VALUE));
    apb(1'h0, PCSTX_SCR_LO_OFFSET, 32'h0000_0000);
    check(rd, PCSTX_SCR_SEED[31:0]);
    apb(1'h0, PCSTX_SCR_HI_OFFSET, 32'h0000_0000);
    check(rd, 32'(PCSTX_SCR_SEED[32]));
    apb(1'h0, PCSTX_STATUS_OFFSET, 32'h0000_0000);
    check(rd, 32'h0000_0000);
    apb(1'h1, 12'h010, 32'hFFFF_FFFF);
    check(32'(er), 32'h0000_0001);
    apb(1'h0, PCSTX_CTRL_OFFSET, 32'h0000_0000);
    check(rd, 32'(PCSTX_CTRL_RESET_VALUE));
    // every mode, both configurations, receiver ok and not; coding reset mid-frame
    for (int k = 0; k < 12; k++) begin
      apb(1'h1, PCSTX_CTRL_OFFSET, 32'((k / 6) * 8 + (k % 3) * 2 + (k / 3) % 2));
      repeat (300) @(posedge pclk);
      apb(1'h1, PCSTX_CTRL_OFFSET, 32'h0000_0010);
    end
    presetn <= 1'h0;
    repeat (2) @(posedge pclk);
    presetn <= 1'h1;
    apb(1'h0, PCSTX_CTRL_OFFSET, 32'h0000_0000);
    check(rd, 32'(PCSTX_CTRL_RESET_VALUE));
    stop_test;
  end

  initial begin
    #100_000;
    mismatches++;
    stop_test;
  end
endmodule
